// >>> design/bbs_boost_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "bbs_defines.svh"

// Resolves the boost output voltage and the switching behaviour actually used.
module bbs_boost_ctrl
	import bbs_pkg::*;
(
	// Control fields and state.
	input  wire logic [7:0]   boost_reg_in,
	input  wire bbs_op_mode_t op_mode_in,
	input  wire logic         running_in,
	input  wire logic         heavy_load_in,
	// Resolved values.
	output logic [12:0]       mv_out,
	output bbs_sw_mode_t      mode_out,
	output bbs_sw_mode_t      active_out
);

	// Voltage select and mode field selection by operating mode.
	always_comb begin
		mv_out = `BBS_BOOST_BASE_MV + 13'(`BBS_STEP_MV * {11'h0, boost_reg_in[`BBS_BOOST_VOLT_LSB +: 2]});
		if (op_mode_in == BBS_OP_NORMAL)
			mode_out = bbs_sw_mode_t'(boost_reg_in[`BBS_BOOST_NORM_LSB +: 2]);
		else
			mode_out = bbs_sw_mode_t'(boost_reg_in[`BBS_BOOST_STBY_LSB +: 2]);
	end

	// Automatic mode picks APS under heavy load and PFM otherwise.
	always_comb begin
		if (!running_in)
			active_out = BBS_SW_OFF;
		else if (mode_out == BBS_SW_AUTO)
			active_out = heavy_load_in ? BBS_SW_APS : BBS_SW_PFM;
		else
			active_out = mode_out;
	end

endmodule // bbs_boost_ctrl

`default_nettype wire

// >>> design/bbs_buck_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "bbs_defines.svh"

// Decodes a buck set-point code to millivolts and its frequency code to kHz.
module bbs_buck_decode (
	bbs_rail_if.dec rail
);

	// Set-point decode; the high range of buck B is a table, the rest are linear.
	always_comb begin
		if (rail.kind_b && rail.high_range) begin
			case (rail.code[2:0])
				3'h0:    rail.mv = 13'd2500;
				3'h1:    rail.mv = 13'd2800;
				3'h2:    rail.mv = 13'd2850;
				3'h3:    rail.mv = 13'd3000;
				3'h4:    rail.mv = 13'd3100;
				3'h5:    rail.mv = 13'd3150;
				3'h6:    rail.mv = 13'd3200;
				default: rail.mv = 13'd3300;
			endcase
		end else if (rail.kind_b) begin
			rail.mv = `BBS_B_LOW_BASE_MV + 13'(`BBS_STEP_MV * {10'h0, rail.code[2:0]});
		end else begin
			rail.mv = `BBS_C_BASE_MV + 13'(`BBS_STEP_MV * {9'h0, rail.code});
		end
	end

	// Frequency decode; code 3 is reserved and flagged as not valid.
	always_comb begin
		rail.freq_ok = 1'b1;
		case (rail.freq_sel)
			2'h0:    rail.khz = `BBS_FREQ_1M_KHZ;
			2'h1:    rail.khz = `BBS_FREQ_2M_KHZ;
			2'h2:    rail.khz = `BBS_FREQ_4M_KHZ;
			default: begin
				rail.khz     = 13'h0;
				rail.freq_ok = 1'b0;
			end
		endcase
	end

endmodule // bbs_buck_decode

`default_nettype wire

// >>> design/bbs_defines.svh
`ifndef BBS_DEFINES_SVH
`define BBS_DEFINES_SVH

// Register addresses.
`define BBS_ADDR_B_NORMAL    8'h35
`define BBS_ADDR_B_STANDBY   8'h36
`define BBS_ADDR_B_SLEEP     8'h37
`define BBS_ADDR_B_MODE      8'h38
`define BBS_ADDR_B_CONFIG    8'h39
`define BBS_ADDR_C_NORMAL    8'h3c
`define BBS_ADDR_C_STANDBY   8'h3d
`define BBS_ADDR_C_SLEEP     8'h3e
`define BBS_ADDR_C_MODE      8'h3f
`define BBS_ADDR_C_CONFIG    8'h40
`define BBS_ADDR_BOOST       8'h66

// Reset values.
`define BBS_RST_SETPOINT     8'h00
`define BBS_RST_MODE         8'h00
`define BBS_RST_B_CONFIG     8'h10
`define BBS_RST_C_CONFIG     8'h10
`define BBS_RST_BOOST        8'h48

// Field positions.
`define BBS_B_CODE_MASK      8'h07
`define BBS_C_CODE_MASK      8'h0f
`define BBS_FREQ_LSB         4
`define BBS_BOOST_VOLT_LSB   0
`define BBS_BOOST_NORM_LSB   2
`define BBS_BOOST_STBY_LSB   5
`define BBS_BOOST_WR_MASK    8'h63
`define BBS_BOOST_RD_MASK    8'h6f

// Voltage and frequency figures, in mV and kHz.
`define BBS_B_LOW_BASE_MV    13'd1500
`define BBS_C_BASE_MV        13'd900
`define BBS_STEP_MV          13'd50
`define BBS_BOOST_BASE_MV    13'd5000
`define BBS_FREQ_1M_KHZ      13'd1000
`define BBS_FREQ_2M_KHZ      13'd2000
`define BBS_FREQ_4M_KHZ      13'd4000

`endif

// >>> design/bbs_pkg.sv
package bbs_pkg;

	// Operating mode of the device as a whole.
	typedef enum logic [1:0] {
		BBS_OP_NORMAL  = 2'h0,
		BBS_OP_STANDBY = 2'h1,
		BBS_OP_SLEEP   = 2'h2
	} bbs_op_mode_t;

	// Boost switching mode coding.
	typedef enum logic [1:0] {
		BBS_SW_OFF  = 2'h0,
		BBS_SW_PFM  = 2'h1,
		BBS_SW_AUTO = 2'h2,
		BBS_SW_APS  = 2'h3
	} bbs_sw_mode_t;

	// Boost power-up sequencing state.
	typedef enum {
		BBS_SEQ_IDLE,
		BBS_SEQ_WAIT,
		BBS_SEQ_ON,
		BBS_SEQ_EXCLUDED
	} bbs_seq_state_t;

endpackage

// >>> design/bbs_rail_if.sv
`timescale 1ns/10ps
`default_nettype none

// Carries one buck set-point code to its decoder and the decoded values back.
interface bbs_rail_if;
	logic [3:0]  code;
	logic        high_range;
	logic        kind_b;
	logic [1:0]  freq_sel;
	logic [12:0] mv;
	logic [12:0] khz;
	logic        freq_ok;
	modport ctrl (output code, high_range, kind_b, freq_sel, input mv, khz, freq_ok);
	modport dec  (input code, high_range, kind_b, freq_sel, output mv, khz, freq_ok);
endinterface

`default_nettype wire

// >>> design/bbs_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "bbs_defines.svh"

// Functional notes
// - Buck B low range: 1.500-1.850 V, 50 mV.
// - Buck B high range uses fixed eight-entry table.
// - Bus writes cannot change buck B range.
// - Buck B normal, standby, sleep codes selected.
// - Buck B registers at 0x35 through 0x39.
// - Buck C code: 0.90 V plus 50 mV/step.
// - Buck C registers at 0x3C through 0x40.
// - All boost control in register 0x66.
// - Boost sequenced only with nonzero factory slot.
// - Boost voltage bits 1:0, 5.000-5.150 V.
// - Boost normal mode bits 3:2, read-only.
// - Boost standby mode bits 6:5, read/write.
// - Automatic mode switches PFM/APS by load.
// - Sequenced boost starts in automatic mode.
// - Frequency code: 1, 2, 4 MHz, 11 reserved.
module bbs_regs
	import bbs_pkg::*;
(
	// Clock and reset.
	input  wire logic         clk_in,
	input  wire logic         reset_in,
	// Register access from the serial interface logic.
	input  wire logic         reg_wr_in,
	input  wire logic         reg_rd_in,
	input  wire logic [7:0]   reg_addr_in,
	input  wire logic [7:0]   reg_wdata_in,
	output logic [7:0]        reg_rdata_out,
	output logic              reg_hit_out,
	// Factory straps.
	input  wire logic         buck_b_factory_high_range_in,
	input  wire logic [2:0]   boost_factory_sequence_slot_in,
	// Power-up sequencer and operating mode.
	input  wire logic         pwrup_step_in,
	input  wire logic [2:0]   pwrup_slot_in,
	input  wire logic         pwrup_done_in,
	input  wire bbs_op_mode_t op_mode_in,
	input  wire logic         boost_heavy_load_in,
	// Buck B outputs.
	output logic [12:0]       buck_b_mv_out,
	output logic [12:0]       buck_b_khz_out,
	output logic              buck_b_freq_ok_out,
	output logic [7:0]        buck_b_mode_out,
	// Buck C outputs.
	output logic [12:0]       buck_c_mv_out,
	output logic [12:0]       buck_c_khz_out,
	output logic              buck_c_freq_ok_out,
	output logic [7:0]        buck_c_mode_out,
	// Boost outputs.
	output logic [12:0]       boost_mv_out,
	output logic              boost_enabled_out,
	output logic              boost_excluded_out,
	output logic [1:0]        boost_switching_out,
	// Latched straps for observation.
	output logic              buck_b_range_out
);

	// Register storage.
	logic [7:0] b_normal_ff, nxt_b_normal;
	logic [7:0] b_standby_ff, nxt_b_standby;
	logic [7:0] b_sleep_ff, nxt_b_sleep;
	logic [7:0] b_mode_ff, nxt_b_mode;
	logic [7:0] b_config_ff, nxt_b_config;
	logic [7:0] c_normal_ff, nxt_c_normal;
	logic [7:0] c_standby_ff, nxt_c_standby;
	logic [7:0] c_sleep_ff, nxt_c_sleep;
	logic [7:0] c_mode_ff, nxt_c_mode;
	logic [7:0] c_config_ff, nxt_c_config;
	logic [7:0] boost_ff, nxt_boost;

	// Read port.
	logic [7:0] rdata_ff, nxt_rdata;
	logic       hit_ff, nxt_hit;

	// Strap capture.
	logic       strap_done_ff, nxt_strap_done;
	logic       high_range_ff, nxt_high_range;
	logic [2:0] boost_slot_ff, nxt_boost_slot;

	// Boost sequencing.
	bbs_seq_state_t seq_state_ff, nxt_seq_state;
	logic           boost_run_ff, nxt_boost_run;

	// Registered outputs.
	logic [12:0] b_mv_ff, nxt_b_mv;
	logic [12:0] b_khz_ff, nxt_b_khz;
	logic        b_fok_ff, nxt_b_fok;
	logic [12:0] c_mv_ff, nxt_c_mv;
	logic [12:0] c_khz_ff, nxt_c_khz;
	logic        c_fok_ff, nxt_c_fok;
	logic [12:0] boost_mv_ff, nxt_boost_mv;
	logic [1:0]  boost_sw_ff, nxt_boost_sw;

	// Decoder links and boost resolution.
	bbs_rail_if   rail_b ();
	bbs_rail_if   rail_c ();
	logic [12:0]  boost_mv;
	bbs_sw_mode_t boost_mode;
	bbs_sw_mode_t boost_active;

	// Selects the set-point code that matches the operating mode.
	function automatic logic [3:0] pick_setpoint(input bbs_op_mode_t mode, input logic [7:0] nrm,
		input logic [7:0] stb, input logic [7:0] slp);
		case (mode)
			BBS_OP_NORMAL:  pick_setpoint = nrm[3:0];
			BBS_OP_STANDBY: pick_setpoint = stb[3:0];
			default:        pick_setpoint = slp[3:0];
		endcase
	endfunction

	// True when a write targets the given address.
	function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] target);
		wr_hit = wr && (addr == target);
	endfunction

	// Register writes; set-point registers keep only their code bits.
	always_comb begin
		nxt_b_normal  = b_normal_ff;
		nxt_b_standby = b_standby_ff;
		nxt_b_sleep   = b_sleep_ff;
		nxt_b_mode    = b_mode_ff;
		nxt_b_config  = b_config_ff;
		nxt_c_normal  = c_normal_ff;
		nxt_c_standby = c_standby_ff;
		nxt_c_sleep   = c_sleep_ff;
		nxt_c_mode    = c_mode_ff;
		nxt_c_config  = c_config_ff;
		nxt_boost     = boost_ff;
		if (wr_hit(reg_wr_in, reg_addr_in, `BBS_ADDR_B_NORMAL))
			nxt_b_normal = reg_wdata_in & `BBS_B_CODE_MASK;
		if (wr_hit(reg_wr_in, reg_addr_in, `BBS_ADDR_B_STANDBY))
			nxt_b_standby = reg_wdata_in & `BBS_B_CODE_MASK;
		if (wr_hit(reg_wr_in, reg_addr_in, `BBS_ADDR_B_SLEEP))
			nxt_b_sleep = reg_wdata_in & `BBS_B_CODE_MASK;
		if (wr_hit(reg_wr_in, reg_addr_in, `BBS_ADDR_B_MODE))
			nxt_b_mode = reg_wdata_in;
		if (wr_hit(reg_wr_in, reg_addr_in, `BBS_ADDR_B_CONFIG))
			nxt_b_config = reg_wdata_in;
		if (wr_hit(reg_wr_in, reg_addr_in, `BBS_ADDR_C_NORMAL))
			nxt_c_normal = reg_wdata_in & `BBS_C_CODE_MASK;
		if (wr_hit(reg_wr_in, reg_addr_in, `BBS_ADDR_C_STANDBY))
			nxt_c_standby = reg_wdata_in & `BBS_C_CODE_MASK;
		if (wr_hit(reg_wr_in, reg_addr_in, `BBS_ADDR_C_SLEEP))
			nxt_c_sleep = reg_wdata_in & `BBS_C_CODE_MASK;
		if (wr_hit(reg_wr_in, reg_addr_in, `BBS_ADDR_C_MODE))
			nxt_c_mode = reg_wdata_in;
		if (wr_hit(reg_wr_in, reg_addr_in, `BBS_ADDR_C_CONFIG))
			nxt_c_config = reg_wdata_in;
		if (wr_hit(reg_wr_in, reg_addr_in, `BBS_ADDR_BOOST)) begin
			nxt_boost = (reg_wdata_in & `BBS_BOOST_WR_MASK) | (boost_ff & ~`BBS_BOOST_WR_MASK);
		end
	end

	// Register update.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			b_normal_ff  <= `BBS_RST_SETPOINT;
			b_standby_ff <= `BBS_RST_SETPOINT;
			b_sleep_ff   <= `BBS_RST_SETPOINT;
			b_mode_ff    <= `BBS_RST_MODE;
			b_config_ff  <= `BBS_RST_B_CONFIG;
			c_normal_ff  <= `BBS_RST_SETPOINT;
			c_standby_ff <= `BBS_RST_SETPOINT;
			c_sleep_ff   <= `BBS_RST_SETPOINT;
			c_mode_ff    <= `BBS_RST_MODE;
			c_config_ff  <= `BBS_RST_C_CONFIG;
			boost_ff     <= `BBS_RST_BOOST;
		end else begin
			b_normal_ff  <= nxt_b_normal;
			b_standby_ff <= nxt_b_standby;
			b_sleep_ff   <= nxt_b_sleep;
			b_mode_ff    <= nxt_b_mode;
			b_config_ff  <= nxt_b_config;
			c_normal_ff  <= nxt_c_normal;
			c_standby_ff <= nxt_c_standby;
			c_sleep_ff   <= nxt_c_sleep;
			c_mode_ff    <= nxt_c_mode;
			c_config_ff  <= nxt_c_config;
			boost_ff     <= nxt_boost;
		end
	end

	// Read decode; unmapped addresses read zero and report no hit.
	always_comb begin
		nxt_rdata = rdata_ff;
		nxt_hit   = hit_ff;
		if (reg_rd_in) begin
			nxt_hit = 1'b1;
			case (reg_addr_in)
				`BBS_ADDR_B_NORMAL:  nxt_rdata = b_normal_ff;
				`BBS_ADDR_B_STANDBY: nxt_rdata = b_standby_ff;
				`BBS_ADDR_B_SLEEP:   nxt_rdata = b_sleep_ff;
				`BBS_ADDR_B_MODE:    nxt_rdata = b_mode_ff;
				`BBS_ADDR_B_CONFIG:  nxt_rdata = b_config_ff;
				`BBS_ADDR_C_NORMAL:  nxt_rdata = c_normal_ff;
				`BBS_ADDR_C_STANDBY: nxt_rdata = c_standby_ff;
				`BBS_ADDR_C_SLEEP:   nxt_rdata = c_sleep_ff;
				`BBS_ADDR_C_MODE:    nxt_rdata = c_mode_ff;
				`BBS_ADDR_C_CONFIG:  nxt_rdata = c_config_ff;
				`BBS_ADDR_BOOST:     nxt_rdata = boost_ff & `BBS_BOOST_RD_MASK;
				default: begin
					nxt_rdata = 8'h00;
					nxt_hit   = 1'b0;
				end
			endcase
		end
	end

	// Read data register.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rdata_ff <= 8'h00;
			hit_ff   <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			hit_ff   <= nxt_hit;
		end
	end

	// Straps are caught once, on the first edge after reset release, and never change after.
	always_comb begin
		nxt_strap_done = 1'b1;
		nxt_high_range = high_range_ff;
		nxt_boost_slot = boost_slot_ff;
		if (!strap_done_ff) begin
			nxt_high_range = buck_b_factory_high_range_in;
			nxt_boost_slot = boost_factory_sequence_slot_in;
		end
	end

	// Strap registers.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			strap_done_ff <= 1'b0;
			high_range_ff <= 1'b0;
			boost_slot_ff <= 3'h0;
		end else begin
			strap_done_ff <= nxt_strap_done;
			high_range_ff <= nxt_high_range;
			boost_slot_ff <= nxt_boost_slot;
		end
	end

	// Boost sequencing: a zero slot keeps the boost out of start-up.
	always_comb begin
		nxt_seq_state = seq_state_ff;
		nxt_boost_run = boost_run_ff;
		case (seq_state_ff)
			BBS_SEQ_IDLE: begin
				if (strap_done_ff) begin
					if (boost_slot_ff == 3'h0)
						nxt_seq_state = BBS_SEQ_EXCLUDED;
					else
						nxt_seq_state = BBS_SEQ_WAIT;
				end
			end
			BBS_SEQ_WAIT: begin
				if (pwrup_step_in && (pwrup_slot_in == boost_slot_ff)) begin
					nxt_seq_state = BBS_SEQ_ON;
					nxt_boost_run = 1'b1;
				end else if (pwrup_done_in) begin
					nxt_seq_state = BBS_SEQ_EXCLUDED;
				end
			end
			BBS_SEQ_ON: begin
				nxt_boost_run = 1'b1;
			end
			BBS_SEQ_EXCLUDED: begin
				nxt_boost_run = 1'b0;
			end
			default: begin
				nxt_seq_state = BBS_SEQ_IDLE;
				nxt_boost_run = 1'b0;
			end
		endcase
	end

	// Sequencer registers.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			seq_state_ff <= BBS_SEQ_IDLE;
			boost_run_ff <= 1'b0;
		end else begin
			seq_state_ff <= nxt_seq_state;
			boost_run_ff <= nxt_boost_run;
		end
	end

	// Buck decoder inputs; the set-point codes are chosen by the operating mode.
	assign rail_b.code       = pick_setpoint(op_mode_in, b_normal_ff, b_standby_ff, b_sleep_ff);
	assign rail_b.high_range = high_range_ff;
	assign rail_b.kind_b     = 1'b1;
	assign rail_b.freq_sel   = b_config_ff[`BBS_FREQ_LSB +: 2];
	assign rail_c.code       = pick_setpoint(op_mode_in, c_normal_ff, c_standby_ff, c_sleep_ff);
	assign rail_c.high_range = 1'b0;
	assign rail_c.kind_b     = 1'b0;
	assign rail_c.freq_sel   = c_config_ff[`BBS_FREQ_LSB +: 2];

	bbs_buck_decode u_dec_b (
		.rail (rail_b.dec)
	);

	bbs_buck_decode u_dec_c (
		.rail (rail_c.dec)
	);

	bbs_boost_ctrl u_boost (
		.boost_reg_in  (boost_ff),
		.op_mode_in    (op_mode_in),
		.running_in    (boost_run_ff),
		.heavy_load_in (boost_heavy_load_in),
		.mv_out        (boost_mv),
		.mode_out      (boost_mode),
		.active_out    (boost_active)
	);

	// Output staging; a freshly sequenced boost runs in automatic mode.
	always_comb begin
		nxt_b_mv     = rail_b.mv;
		nxt_b_khz    = rail_b.khz;
		nxt_b_fok    = rail_b.freq_ok;
		nxt_c_mv     = rail_c.mv;
		nxt_c_khz    = rail_c.khz;
		nxt_c_fok    = rail_c.freq_ok;
		nxt_boost_mv = boost_mv;
		nxt_boost_sw = boost_active;
		if (boost_run_ff && !nxt_boost_run)
			nxt_boost_sw = BBS_SW_OFF;
		if (nxt_boost_run && !boost_run_ff)
			nxt_boost_sw = boost_heavy_load_in ? BBS_SW_APS : BBS_SW_PFM;
	end

	// Output registers.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			b_mv_ff     <= `BBS_B_LOW_BASE_MV;
			b_khz_ff    <= `BBS_FREQ_2M_KHZ;
			b_fok_ff    <= 1'b1;
			c_mv_ff     <= `BBS_C_BASE_MV;
			c_khz_ff    <= `BBS_FREQ_2M_KHZ;
			c_fok_ff    <= 1'b1;
			boost_mv_ff <= `BBS_BOOST_BASE_MV;
			boost_sw_ff <= 2'h0;
		end else begin
			b_mv_ff     <= nxt_b_mv;
			b_khz_ff    <= nxt_b_khz;
			b_fok_ff    <= nxt_b_fok;
			c_mv_ff     <= nxt_c_mv;
			c_khz_ff    <= nxt_c_khz;
			c_fok_ff    <= nxt_c_fok;
			boost_mv_ff <= nxt_boost_mv;
			boost_sw_ff <= nxt_boost_sw;
		end
	end

	// Port drive.
	assign reg_rdata_out       = rdata_ff;
	assign reg_hit_out         = hit_ff;
	assign buck_b_mv_out       = b_mv_ff;
	assign buck_b_khz_out      = b_khz_ff;
	assign buck_b_freq_ok_out  = b_fok_ff;
	assign buck_b_mode_out     = b_mode_ff;
	assign buck_c_mv_out       = c_mv_ff;
	assign buck_c_khz_out      = c_khz_ff;
	assign buck_c_freq_ok_out  = c_fok_ff;
	assign buck_c_mode_out     = c_mode_ff;
	assign boost_mv_out        = boost_mv_ff;
	assign boost_enabled_out   = boost_run_ff;
	assign boost_excluded_out  = (seq_state_ff == BBS_SEQ_EXCLUDED);
	assign boost_switching_out = boost_sw_ff;
	assign buck_b_range_out    = high_range_ff;

endmodule // bbs_regs

`default_nettype wire

// >>> dv/bbs_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// Host side of the register strobes; requests change only at falling edges.
module bbs_host_model (
	// Clock.
	input  wire logic       clk_in,
	// Strobes toward the block.
	output logic            reg_wr_out,
	output logic            reg_rd_out,
	output logic [7:0]      reg_addr_out,
	output logic [7:0]      reg_wdata_out,
	// Read answer.
	input  wire logic [7:0] reg_rdata_in,
	input  wire logic       reg_hit_in
);
	// Bus idle at time zero.
	initial begin
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		reg_addr_out = 8'h00;
		reg_wdata_out = 8'h00;
	end

	// One write; the host only carries codes, never the range strap.
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge clk_in);
		reg_wr_out = 1'b1;
		reg_addr_out = addr;
		reg_wdata_out = data;
		@(negedge clk_in);
		reg_wr_out = 1'b0;
		reg_addr_out = ~addr;
		reg_wdata_out = ~data;
	endtask

	// One read; the answer is taken half a cycle after the taking edge.
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic hit);
		@(negedge clk_in);
		reg_rd_out = 1'b1;
		reg_addr_out = addr;
		@(negedge clk_in);
		reg_rd_out = 1'b0;
		reg_addr_out = ~addr;
		data = reg_rdata_in;
		hit = reg_hit_in;
	endtask
endmodule // bbs_host_model

`default_nettype wire

// >>> dv/bbs_regs_assertions.sv
`timescale 1ns/10ps
`default_nettype none

// Watches the register bank ports.
module bbs_regs_checker
	import bbs_pkg::*;
(
	// Clock, reset and register bus.
	input  wire logic         clk_in,
	input  wire logic         reset_in,
	input  wire logic         reg_rd_in,
	input  wire logic [7:0]   reg_addr_in,
	input  wire logic [7:0]   reg_rdata_out,
	input  wire logic         reg_hit_out,
	// Mode inputs and rail outputs.
	input  wire bbs_op_mode_t op_mode_in,
	input  wire logic         boost_heavy_load_in,
	input  wire logic [12:0]  buck_b_mv_out,
	input  wire logic [12:0]  buck_b_khz_out,
	input  wire logic         buck_b_freq_ok_out,
	input  wire logic [12:0]  buck_c_mv_out,
	input  wire logic [12:0]  boost_mv_out,
	input  wire logic         boost_enabled_out,
	input  wire logic         boost_excluded_out,
	input  wire logic [1:0]   boost_switching_out,
	input  wire logic         buck_b_range_out
);
	// All checks share one clock and stay quiet while reset is high.
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	// Marks the eleven mapped register addresses.
	logic mapped;
	assign mapped = reg_addr_in inside {[8'h35:8'h39], [8'h3c:8'h40], 8'h66};

	rd_unmapped_a: assert property (reg_rd_in && !mapped |=> !reg_hit_out && reg_rdata_out == 8'h00)
		else $error("unmapped read gave data or hit");
	rd_mapped_a: assert property (reg_rd_in && mapped |=> reg_hit_out)
		else $error("mapped read gave no hit");
	boost_fixed_a: assert property (reg_rd_in && reg_addr_in == 8'h66 |=>
		reg_rdata_out[7] == 1'b0 && reg_rdata_out[4] == 1'b0 && reg_rdata_out[3:2] == 2'b10)
		else $error("boost fixed bits read wrong");
	b_low_a: assert property (!buck_b_range_out && !$past(buck_b_range_out, 2) |->
		buck_b_mv_out inside {[13'd1500:13'd1850]} && buck_b_mv_out % 13'd50 == 13'd0)
		else $error("buck b low range value wrong");
	b_high_a: assert property (buck_b_range_out && $past(buck_b_range_out, 2) |-> buck_b_mv_out inside
		{13'd2500, 13'd2800, 13'd2850, 13'd3000, 13'd3100, 13'd3150, 13'd3200, 13'd3300})
		else $error("buck b high range value wrong");
	c_step_a: assert property (buck_c_mv_out inside {[13'd900:13'd1650]} &&
		(buck_c_mv_out - 13'd900) % 13'd50 == 13'd0)
		else $error("buck c value off its steps");
	freq_code_a: assert property (buck_b_freq_ok_out ? (buck_b_khz_out inside {13'd1000, 13'd2000, 13'd4000})
		: (buck_b_khz_out == 13'd0))
		else $error("buck b frequency wrong");
	boost_volt_a: assert property (boost_mv_out inside {13'd5000, 13'd5050, 13'd5100, 13'd5150})
		else $error("boost voltage off its steps");
	excl_off_a: assert property (boost_excluded_out |-> !boost_enabled_out)
		else $error("excluded boost was enabled");
	enable_holds_a: assert property (boost_enabled_out |=> boost_enabled_out)
		else $error("boost enable dropped");
	auto_load_a: assert property (boost_enabled_out && $past(boost_enabled_out) && $past(op_mode_in) == BBS_OP_NORMAL
		|-> boost_switching_out == ($past(boost_heavy_load_in) ? 2'h3 : 2'h1))
		else $error("automatic mode did not follow load");
	range_fixed_a: assert property (!$past(reset_in) && !$past(reset_in, 2) |-> $stable(buck_b_range_out))
		else $error("buck b range changed without reset");
endmodule // bbs_regs_checker

bind bbs_regs bbs_regs_checker i_chk (
	.clk_in, .reset_in, .reg_rd_in, .reg_addr_in, .reg_rdata_out, .reg_hit_out, .op_mode_in,
	.boost_heavy_load_in, .buck_b_mv_out, .buck_b_khz_out, .buck_b_freq_ok_out, .buck_c_mv_out,
	.boost_mv_out, .boost_enabled_out, .boost_excluded_out, .boost_switching_out, .buck_b_range_out
);

`default_nettype wire

// >>> dv/bbs_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none

module bbs_regs_tb
	import bbs_pkg::*;
;
	typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rdata; logic hit;} bbs_row_t;
	// Address, data written, value read back and hit flag.
	bbs_row_t rows [14] = '{'{8'h35, 8'hff, 8'h07, 1'b1}, '{8'h36, 8'h0d, 8'h05, 1'b1},
		'{8'h37, 8'hfa, 8'h02, 1'b1}, '{8'h38, 8'ha5, 8'ha5, 1'b1}, '{8'h39, 8'h2c, 8'h2c, 1'b1},
		'{8'h3c, 8'hff, 8'h0f, 1'b1}, '{8'h3d, 8'h93, 8'h03, 1'b1}, '{8'h3e, 8'h5a, 8'h0a, 1'b1},
		'{8'h3f, 8'h3c, 8'h3c, 1'b1}, '{8'h40, 8'h01, 8'h01, 1'b1}, '{8'h66, 8'hff, 8'h6b, 1'b1},
		'{8'h66, 8'h00, 8'h08, 1'b1}, '{8'h3a, 8'hff, 8'h00, 1'b0}, '{8'h34, 8'hff, 8'h00, 1'b0}};
	logic [12:0] hi_mv [8] = '{13'd2500, 13'd2800, 13'd2850, 13'd3000, 13'd3100, 13'd3150, 13'd3200, 13'd3300};
	logic [12:0] khz_tab [4] = '{13'd1000, 13'd2000, 13'd4000, 13'd0};
	logic [12:0] mode_mv [3] = '{13'd1550, 13'd1750, 13'd1600};
	logic [1:0]  stby_sw [4] = '{2'h0, 2'h1, 2'h3, 2'h3};
	int           check_count = 0;
	int           fail_count = 0;
	logic         clk_in, reset_in, range_strap, pwrup_step, pwrup_done, heavy;
	logic         reg_wr, reg_rd, reg_hit, b_ok, boost_en, boost_excl, b_range, c_ok;
	logic [2:0]   slot_strap, pwrup_slot;
	logic [7:0]   reg_addr, reg_wdata, reg_rdata, b_mode, c_mode;
	logic [12:0]  b_mv, b_khz, c_mv, boost_mv, c_khz;
	logic [1:0]   boost_sw;
	bbs_op_mode_t op_mode;

	// Block and host.
	bbs_regs i_dut (.clk_in(clk_in), .reset_in(reset_in), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
		.reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata), .reg_hit_out(reg_hit),
		.buck_b_factory_high_range_in(range_strap), .boost_factory_sequence_slot_in(slot_strap),
		.pwrup_step_in(pwrup_step), .pwrup_slot_in(pwrup_slot), .pwrup_done_in(pwrup_done),
		.op_mode_in(op_mode), .boost_heavy_load_in(heavy), .buck_b_mv_out(b_mv), .buck_b_khz_out(b_khz),
		.buck_b_freq_ok_out(b_ok), .buck_b_mode_out(b_mode), .buck_c_mv_out(c_mv), .buck_c_khz_out(c_khz),
		.buck_c_freq_ok_out(c_ok), .buck_c_mode_out(c_mode), .boost_mv_out(boost_mv), .boost_enabled_out(boost_en),
		.boost_excluded_out(boost_excl), .boost_switching_out(boost_sw), .buck_b_range_out(b_range));
	bbs_host_model i_host (.clk_in(clk_in), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd), .reg_addr_out(reg_addr),
		.reg_wdata_out(reg_wdata), .reg_rdata_in(reg_rdata), .reg_hit_in(reg_hit));

	// Free-running 100 ns clock.
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	// Compares one value and counts it.
	task automatic check(input string name, input logic [12:0] exp, input logic [12:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	// Reads a register and compares data and hit.
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic hit);
		logic [7:0] d;
		logic       h;
		i_host.read_reg(a, d, h);
		check("rdata", {5'h00, exp}, {5'h00, d});
		check("hit", {12'h000, hit}, {12'h000, h});
	endtask

	// Holds reset for eight cycles with the given straps.
	task automatic do_reset(input logic rng, input logic [2:0] slot);
		reset_in = 1'b1;
		range_strap = rng;
		slot_strap = slot;
		repeat (8) @(negedge clk_in);
		reset_in = 1'b0;
		repeat (2) @(negedge clk_in);
	endtask

	task automatic settle(input int n);
		repeat (n) @(negedge clk_in);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Main sequence.
	initial begin
		{pwrup_step, pwrup_done, heavy, pwrup_slot} = '0;
		op_mode = BBS_OP_NORMAL;
		do_reset(1'b0, 3'h3);
		rd_chk(8'h35, 8'h00, 1'b1);
		rd_chk(8'h39, 8'h10, 1'b1);
		rd_chk(8'h40, 8'h10, 1'b1);
		rd_chk(8'h66, 8'h48, 1'b1);
		foreach (rows[i]) begin
			i_host.write_reg(rows[i].addr, rows[i].wdata);
			rd_chk(rows[i].addr, rows[i].rdata, rows[i].hit);
		end
		check("b_mode", 13'h00a5, {5'h00, b_mode});
		check("c_mode", 13'h003c, {5'h00, c_mode});
		for (int c = 0; c < 16; c++) begin
			i_host.write_reg(8'h3c, c[7:0]);
			i_host.write_reg(8'h35, c[7:0] | 8'hf8);
			settle(1);
			check("c_mv", 13'd900 + 13'd50 * c[12:0], c_mv);
			check("b_mv", 13'd1500 + 13'd50 * {10'h000, c[2:0]}, b_mv);
		end
		for (int f = 0; f < 4; f++) begin
			i_host.write_reg(8'h39, {2'b00, f[1:0], 4'h0});
			i_host.write_reg(8'h40, {2'b00, f[1:0], 4'h0});
			settle(1);
			check("b_khz", khz_tab[f], b_khz);
			check("b_ok", {12'h000, f != 3}, {12'h000, b_ok});
			check("c_khz", khz_tab[f], c_khz);
			check("c_ok", {12'h000, f != 3}, {12'h000, c_ok});
		end
		for (int v = 0; v < 4; v++) begin
			i_host.write_reg(8'h66, {6'h10, v[1:0]});
			settle(1);
			check("boost_mv", 13'd5000 + 13'd50 * v[12:0], boost_mv);
		end
		i_host.write_reg(8'h35, 8'h01);
		i_host.write_reg(8'h36, 8'h05);
		i_host.write_reg(8'h37, 8'h02);
		for (int m = 0; m < 3; m++) begin
			op_mode = bbs_op_mode_t'(m[1:0]);
			settle(1);
			check("mode_mv", mode_mv[m], b_mv);
		end
		op_mode = BBS_OP_NORMAL;
		do_reset(1'b1, 3'h3);
		check("range", 13'h0001, {12'h000, b_range});
		for (int c = 0; c < 8; c++) begin
			i_host.write_reg(8'h35, c[7:0] | 8'hf8);
			settle(1);
			check("b_hi_mv", hi_mv[c], b_mv);
		end
		check("range", 13'h0001, {12'h000, b_range});
		pwrup_slot = 3'h2;
		pwrup_step = 1'b1;
		settle(1);
		pwrup_step = 1'b0;
		settle(2);
		check("early_en", 13'h0000, {12'h000, boost_en});
		pwrup_slot = 3'h3;
		pwrup_step = 1'b1;
		settle(1);
		pwrup_step = 1'b0;
		for (int k = 0; k < 8 && boost_en !== 1'b1; k++) begin
			settle(1);
		end
		if (boost_en !== 1'b1) begin
			fail_count++;
			$display("MISMATCH boost_en expected 1 seen %b", boost_en);
			complete_run();
		end
		settle(1);
		check("sw_light", 13'h0001, {11'h000, boost_sw});
		heavy = 1'b1;
		settle(2);
		check("sw_heavy", 13'h0003, {11'h000, boost_sw});
		op_mode = BBS_OP_STANDBY;
		for (int s = 0; s < 4; s++) begin
			i_host.write_reg(8'h66, {1'b0, s[1:0], 5'h00});
			settle(1);
			check("sw_stby", {11'h000, stby_sw[s]}, {11'h000, boost_sw});
		end
		op_mode = BBS_OP_NORMAL;
		do_reset(1'b0, 3'h0);
		pwrup_slot = 3'h0;
		pwrup_step = 1'b1;
		settle(1);
		pwrup_step = 1'b0;
		settle(2);
		check("excl", 13'h0001, {12'h000, boost_excl});
		check("excl_en", 13'h0000, {12'h000, boost_en});
		complete_run();
	end
endmodule // bbs_regs_tb

`default_nettype wire
